/* verilog/bpe_pkg.sv */
// Package for the parity and error block of the bridge: config offsets,
// field positions, reset values, carriers and shared functions.
// Assumes one PCI clock domain and an active-low asynchronous reset.
//
// What this block does
// - Check address parity on every address phase of both buses.
// - Bad address parity with response bit set: do not claim the cycle.
// - Bad address parity sets detected parity error in that bus's status.
// - Bad address parity signals system error if enable and response set.
// - Bad config write data: ready, store data, parity error if response set.
// - Bad config write data always sets primary detected parity error.
// - Bad read data on target bus: parity error two cycles later if enabled.
// - Bad read data sets detected, and data parity bit when enabled.
// - Read data returns to the initiator with its parity unchanged.
// - Prefetched data never read is discarded and never returned.
// - Initiator parity error during read return causes no further action.
// - A queued delayed write captures address, command, data, parities; retry.
// - Bad initial delayed write, response set: ready, no queue, error pulse.
// - Bad initial delayed write, response clear: retry and queue normally.
// - Bad initial delayed write always sets detected parity error.
// - Secondary target parity error on delivery: data parity bit if response set, keep error.
// - Primary target parity error on delivery: data parity bit if response set, keep error.
// - Reattempt completes only on equal address, command, data, enables.
// - Forwarded data keeps its parity condition unchanged.
// - System error only with enable set, always sets signaled bit.

`default_nettype none

package bpe_pkg;

    // ----
    // Register offsets and fields
    // ----
    localparam logic [7:0] OFS_CMD_STATUS = 8'h04;
    localparam logic [7:0] OFS_SEC_STATUS = 8'h1C;
    localparam logic [7:0] OFS_BRIDGE_CTRL = 8'h3C;
    localparam int CMD_PERR_RESP = 6;
    localparam int CMD_SERR_EN = 8;
    localparam int BCTL_PERR_RESP = 0;
    localparam int ST_DATA_PAR = 8;
    localparam int ST_SIG_SERR = 14;
    localparam int ST_DET_PAR = 15;
    localparam logic [15:0] PRI_STATUS_W1C = 16'hC100;
    localparam logic [15:0] SEC_STATUS_W1C = 16'h8100;
    localparam logic [15:0] CMD_RESET = 16'h0000;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] BCTL_RESET = 16'h0000;

    // ----
    // Timing
    // ----
    localparam int PERR_DELAY = 2;

    // ----
    // Carriers
    // ----
    typedef struct packed {
        logic addr_phase;
        logic data_phase;
        logic [31:0] ad;
        logic [3:0] cbe_n;
        logic par;
        logic perr_n;
        logic hit;
        logic cfg_wr;
        logic rd_target;
        logic rd_return;
        logic rd_discard;
        logic dw_req;
        logic dw_deliver;
        logic more;
    } bpe_bus_t;

    typedef struct packed {
        logic valid;
        logic [31:0] ad;
        logic par;
    } bpe_fwd_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [3:0] cmd;
        logic apar;
    } bpe_addr_t;

    typedef struct packed {
        logic valid;
        logic err;
        bpe_addr_t a;
        logic [31:0] data;
        logic [3:0] be_n;
        logic dpar;
    } bpe_dw_t;

    localparam bpe_fwd_t FWD_IDLE = '0;
    localparam bpe_addr_t ADDR_RESET = '0;
    localparam bpe_dw_t DW_EMPTY = '0;

    // ----
    // Functions
    // ----
    // Even parity over AD, C/BE# and PAR; high means a parity error.
    function automatic logic par_bad(input logic [31:0] ad,
                                     input logic [3:0] cbe_n,
                                     input logic par);
        return ^{ad, cbe_n, par};
    endfunction

    // Byte lanes of a half word kept where the enable is high.
    function automatic logic [15:0] lanes16(input logic [15:0] d,
                                            input logic [1:0] be);
        return {be[1] ? d[15:8] : 8'h00, be[0] ? d[7:0] : 8'h00};
    endfunction

    // Reattempt equals the queued entry; parity is left out.
    function automatic logic dw_same(input bpe_dw_t e,
                                     input bpe_addr_t a,
                                     input logic [31:0] data,
                                     input logic [3:0] be_n);
        return e.a.addr == a.addr && e.a.cmd == a.cmd &&
               e.data == data && e.be_n == be_n;
    endfunction

endpackage

`default_nettype wire

/* verilog/bpe_perr_delay.sv */
// Delay line that turns a parity error decision into a one-cycle
// active-low parity error pulse, PERR_DELAY cycles after the transfer.
// Assumes fire is high in the data transfer cycle only.

`default_nettype none

module bpe_perr_delay (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fire,
    output logic parity_error_n
);

    logic [bpe_pkg::PERR_DELAY-1:0] pipe_n;

    // ----
    // Active-low shift line
    // ----
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pipe_n <= '1;
        end else begin
            pipe_n <= {pipe_n[bpe_pkg::PERR_DELAY-2:0], ~fire};
        end
    end

    assign parity_error_n = pipe_n[bpe_pkg::PERR_DELAY-1];

endmodule

`default_nettype wire

/* verilog/bpe_parity_core.sv */
// Parity checking, error signalling and parity forwarding of the bridge.
// Assumes the bus interfaces present decoded phase strobes on PRI_BUS and
// SEC_BUS in the transfer cycle, all synchronous to CORE_CLK.

`default_nettype none

module bpe_parity_core (
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire bpe_pkg::bpe_bus_t PRI_BUS,
    input wire bpe_pkg::bpe_bus_t SEC_BUS,
    input wire logic CFG_RD,
    input wire logic [7:0] CFG_ADDR,
    output logic [31:0] CFG_RDATA,
    output logic PRIMARY_DEVICE_SELECT_N,
    output logic SECONDARY_DEVICE_SELECT_N,
    output logic PRIMARY_TARGET_READY_N,
    output logic SECONDARY_TARGET_READY_N,
    output logic PRIMARY_STOP_N,
    output logic SECONDARY_STOP_N,
    output logic PRIMARY_SYSTEM_ERROR_N,
    output logic PRIMARY_PARITY_ERROR_N,
    output logic SECONDARY_PARITY_ERROR_N,
    output bpe_pkg::bpe_fwd_t PRI_FWD_OUT,
    output bpe_pkg::bpe_fwd_t SEC_FWD_OUT,
    output logic [1:0] DW_KEPT_ERROR
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [15:0] cmd;
    logic [15:0] bctl;
    logic [15:0] status [2];
    bpe_pkg::bpe_addr_t alat [2];
    bpe_pkg::bpe_dw_t dw [2];
    bpe_pkg::bpe_fwd_t fwd [2];
    bpe_pkg::bpe_fwd_t fwd_drv [2];
    logic [1:0] sel_n;
    logic [1:0] rdy_n;
    logic [1:0] stp_n;
    logic serr_n;

    logic [15:0] next_cmd;
    logic [15:0] next_bctl;
    logic [15:0] next_status [2];
    bpe_pkg::bpe_addr_t next_alat [2];
    bpe_pkg::bpe_dw_t next_dw [2];
    bpe_pkg::bpe_fwd_t next_fwd [2];
    bpe_pkg::bpe_fwd_t next_drv [2];
    logic [31:0] next_rdata;

    // ------------------------------------------------------------------
    // Bus views
    // ------------------------------------------------------------------
    bpe_pkg::bpe_bus_t bus [2];
    logic [1:0] addr_phase;
    logic [1:0] data_phase;
    logic [1:0] resp;
    logic [1:0] addr_bad;
    logic [1:0] data_bad;

    assign bus[0] = PRI_BUS;
    assign bus[1] = SEC_BUS;
    assign addr_phase = {SEC_BUS.addr_phase, PRI_BUS.addr_phase};
    assign data_phase = {SEC_BUS.data_phase, PRI_BUS.data_phase};
    assign resp = {bctl[bpe_pkg::BCTL_PERR_RESP],
                   cmd[bpe_pkg::CMD_PERR_RESP]};

    assign addr_bad[0] = PRI_BUS.addr_phase &
        bpe_pkg::par_bad(PRI_BUS.ad, PRI_BUS.cbe_n, PRI_BUS.par);
    assign addr_bad[1] = SEC_BUS.addr_phase &
        bpe_pkg::par_bad(SEC_BUS.ad, SEC_BUS.cbe_n, SEC_BUS.par);
    assign data_bad[0] = PRI_BUS.data_phase &
        bpe_pkg::par_bad(PRI_BUS.ad, PRI_BUS.cbe_n, PRI_BUS.par);
    assign data_bad[1] = SEC_BUS.data_phase &
        bpe_pkg::par_bad(SEC_BUS.ad, SEC_BUS.cbe_n, SEC_BUS.par);

    // ------------------------------------------------------------------
    // Address phase decisions
    // ------------------------------------------------------------------
    logic [1:0] hit;
    logic [1:0] claim;
    logic [1:0] serr_ev;

    assign hit = {SEC_BUS.hit, PRI_BUS.hit};
    assign claim = addr_phase & hit & ~(addr_bad & resp);
    assign serr_ev = addr_bad & resp &
        {2{cmd[bpe_pkg::CMD_SERR_EN]}};

    // ------------------------------------------------------------------
    // Configuration write on the primary bus
    // ------------------------------------------------------------------
    logic cfg_we;
    logic cfg_bad;
    logic [3:0] cfg_be;
    logic wr_cs;
    logic wr_ss;
    logic wr_bc;

    assign cfg_we = PRI_BUS.data_phase & PRI_BUS.cfg_wr;
    assign cfg_bad = cfg_we & data_bad[0];
    assign cfg_be = ~PRI_BUS.cbe_n;
    assign wr_cs = cfg_we && CFG_ADDR == bpe_pkg::OFS_CMD_STATUS;
    assign wr_ss = cfg_we && CFG_ADDR == bpe_pkg::OFS_SEC_STATUS;
    assign wr_bc = cfg_we && CFG_ADDR == bpe_pkg::OFS_BRIDGE_CTRL;

    // ------------------------------------------------------------------
    // Read and delayed write data phase decisions
    // ------------------------------------------------------------------
    logic [1:0] rd_err;
    logic [1:0] dw_req;
    logic [1:0] dw_valid;
    logic [1:0] dw_match;
    logic [1:0] dw_init;
    logic [1:0] dw_drop;
    logic [1:0] dw_queue;
    logic [1:0] dw_hit;
    logic [1:0] dw_busy;
    logic [1:0] tperr;
    logic [1:0] more;
    logic [1:0] trdy;
    logic [1:0] stop;
    logic [1:0] perr_fire;
    logic [1:0] det_set;
    logic [1:0] dpd_set;

    assign rd_err = data_bad & {SEC_BUS.rd_target, PRI_BUS.rd_target};
    assign dw_req = data_phase & {SEC_BUS.dw_req, PRI_BUS.dw_req};
    assign dw_valid = {dw[1].valid, dw[0].valid};
    assign dw_match[0] = bpe_pkg::dw_same(dw[0], alat[0],
        PRI_BUS.ad, PRI_BUS.cbe_n);
    assign dw_match[1] = bpe_pkg::dw_same(dw[1], alat[1],
        SEC_BUS.ad, SEC_BUS.cbe_n);
    assign dw_init = dw_req & ~dw_valid;
    assign dw_drop = dw_init & data_bad & resp;
    assign dw_queue = dw_init & ~dw_drop;
    assign dw_hit = dw_req & dw_valid & dw_match;
    assign dw_busy = dw_req & dw_valid & ~dw_match;
    assign tperr = {SEC_BUS.dw_deliver & ~SEC_BUS.perr_n,
                    PRI_BUS.dw_deliver & ~PRI_BUS.perr_n};
    assign more = {SEC_BUS.more, PRI_BUS.more};

    assign trdy = dw_drop | dw_hit | {1'b0, cfg_we};
    assign stop = (trdy & more) | dw_queue | dw_busy;
    assign perr_fire = (rd_err & resp)
        | dw_drop
        | {1'b0, cfg_bad & resp[0]};
    assign det_set = addr_bad
        | rd_err
        | (dw_init & data_bad)
        | {1'b0, cfg_bad};
    assign dpd_set = (rd_err & resp)
        | (tperr & resp);

    // ------------------------------------------------------------------
    // Register next values
    // ------------------------------------------------------------------
    logic [15:0] cs_mask;
    logic [15:0] bc_mask;
    logic [15:0] hi_lanes;
    logic [15:0] clr [2];
    logic [15:0] set [2];

    assign cs_mask = bpe_pkg::lanes16(16'hFFFF, cfg_be[1:0]);
    assign bc_mask = bpe_pkg::lanes16(16'hFFFF, cfg_be[3:2]);
    assign hi_lanes = bpe_pkg::lanes16(PRI_BUS.ad[31:16], cfg_be[3:2]);
    assign next_cmd = wr_cs ?
        (cmd & ~cs_mask) | (PRI_BUS.ad[15:0] & cs_mask) : cmd;
    assign next_bctl = wr_bc ?
        (bctl & ~bc_mask) | (PRI_BUS.ad[31:16] & bc_mask) : bctl;
    assign clr[0] = wr_cs ? hi_lanes & bpe_pkg::PRI_STATUS_W1C : 16'h0000;
    assign clr[1] = wr_ss ? hi_lanes & bpe_pkg::SEC_STATUS_W1C : 16'h0000;
    assign set[0] = (16'(det_set[0]) << bpe_pkg::ST_DET_PAR)
        | (16'(|serr_ev) << bpe_pkg::ST_SIG_SERR)
        | (16'(dpd_set[0]) << bpe_pkg::ST_DATA_PAR);
    assign set[1] = (16'(det_set[1]) << bpe_pkg::ST_DET_PAR)
        | (16'(dpd_set[1]) << bpe_pkg::ST_DATA_PAR);
    // A set in the same cycle as a write-one clear wins.
    assign next_status[0] = (status[0] & ~clr[0]) | set[0];
    assign next_status[1] = (status[1] & ~clr[1]) | set[1];

    assign next_rdata =
        CFG_ADDR == bpe_pkg::OFS_CMD_STATUS ? {status[0], cmd} :
        CFG_ADDR == bpe_pkg::OFS_SEC_STATUS ? {status[1], 16'h0000} :
        CFG_ADDR == bpe_pkg::OFS_BRIDGE_CTRL ? {bctl, 16'h0000} :
        32'h0000_0000;

    // ------------------------------------------------------------------
    // Queues and forwarding
    // ------------------------------------------------------------------
    always_comb begin
        for (int b = 0; b < 2; b++) begin
            next_alat[b] = alat[b];
            next_dw[b] = dw[b];
            next_fwd[b] = fwd[b];
            next_drv[b] = bpe_pkg::FWD_IDLE;
            if (addr_phase[b]) begin
                next_alat[b].addr = bus[b].ad;
                next_alat[b].cmd = bus[b].cbe_n;
                next_alat[b].apar = bus[b].par;
            end
            if (dw_queue[b]) begin
                next_dw[b].valid = 1'b1;
                next_dw[b].err = 1'b0;
                next_dw[b].a = alat[b];
                next_dw[b].data = bus[b].ad;
                next_dw[b].be_n = bus[b].cbe_n;
                next_dw[b].dpar = bus[b].par;
            end else if (dw_hit[b]) begin
                next_dw[b].valid = 1'b0;
                next_dw[b].err = 1'b0;
            end
            if (tperr[1-b] && dw[b].valid) begin
                next_dw[b].err = 1'b1;
            end
            // Initiator PERR# on read return is left to the initiator.
            if (data_phase[b] && bus[b].rd_return) begin
                next_drv[b] = fwd[b];
                next_fwd[b].valid = 1'b0;
            end else if (data_phase[b] && bus[b].dw_deliver) begin
                next_drv[b].valid = dw[1-b].valid;
                next_drv[b].ad = dw[1-b].data;
                next_drv[b].par = dw[1-b].dpar;
            end
            if (bus[b].rd_discard) begin
                next_fwd[b] = bpe_pkg::FWD_IDLE;
            end
            if (data_phase[1-b] && bus[1-b].rd_target) begin
                next_fwd[b].valid = 1'b1;
                next_fwd[b].ad = bus[1-b].ad;
                next_fwd[b].par = bus[1-b].par;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cmd <= bpe_pkg::CMD_RESET;
            bctl <= bpe_pkg::BCTL_RESET;
            CFG_RDATA <= 32'h0000_0000;
        end else begin
            cmd <= next_cmd;
            bctl <= next_bctl;
            CFG_RDATA <= CFG_RD ? next_rdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            for (int b = 0; b < 2; b++) begin
                status[b] <= bpe_pkg::STATUS_RESET;
                alat[b] <= bpe_pkg::ADDR_RESET;
                dw[b] <= bpe_pkg::DW_EMPTY;
                fwd[b] <= bpe_pkg::FWD_IDLE;
                fwd_drv[b] <= bpe_pkg::FWD_IDLE;
            end
        end else begin
            for (int b = 0; b < 2; b++) begin
                status[b] <= next_status[b];
                alat[b] <= next_alat[b];
                dw[b] <= next_dw[b];
                fwd[b] <= next_fwd[b];
                fwd_drv[b] <= next_drv[b];
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sel_n <= 2'b11;
            rdy_n <= 2'b11;
            stp_n <= 2'b11;
            serr_n <= 1'b1;
        end else begin
            sel_n <= ~claim;
            rdy_n <= ~trdy;
            stp_n <= ~stop;
            serr_n <= ~|serr_ev;
        end
    end

    // ------------------------------------------------------------------
    // Parity error pulses
    // ------------------------------------------------------------------
    bpe_perr_delay u_pri_perr (
        .clk(CORE_CLK),
        .rst_n(RSTN),
        .fire(perr_fire[0]),
        .parity_error_n(PRIMARY_PARITY_ERROR_N)
    );

    bpe_perr_delay u_sec_perr (
        .clk(CORE_CLK),
        .rst_n(RSTN),
        .fire(perr_fire[1]),
        .parity_error_n(SECONDARY_PARITY_ERROR_N)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign PRIMARY_DEVICE_SELECT_N = sel_n[0];
    assign SECONDARY_DEVICE_SELECT_N = sel_n[1];
    assign PRIMARY_TARGET_READY_N = rdy_n[0];
    assign SECONDARY_TARGET_READY_N = rdy_n[1];
    assign PRIMARY_STOP_N = stp_n[0];
    assign SECONDARY_STOP_N = stp_n[1];
    assign PRIMARY_SYSTEM_ERROR_N = serr_n;
    assign PRI_FWD_OUT = fwd_drv[0];
    assign SEC_FWD_OUT = fwd_drv[1];
    assign DW_KEPT_ERROR = {dw[1].err, dw[0].err};

endmodule

`default_nettype wire

/* testbench/bpe_parity_core_properties.sv */
// Concurrent checks on the ports of the parity and error block.
// Assumes one clock domain and the active-low reset of the design.
`default_nettype none
module bpe_chk (
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire bpe_pkg::bpe_bus_t PRI_BUS,
    input wire bpe_pkg::bpe_bus_t SEC_BUS,
    input wire logic PRIMARY_DEVICE_SELECT_N,
    input wire logic SECONDARY_DEVICE_SELECT_N,
    input wire logic PRIMARY_TARGET_READY_N,
    input wire logic PRIMARY_STOP_N,
    input wire logic PRIMARY_SYSTEM_ERROR_N,
    input wire logic PRIMARY_PARITY_ERROR_N,
    input wire logic SECONDARY_PARITY_ERROR_N,
    input wire bpe_pkg::bpe_fwd_t PRI_FWD_OUT
);
    // ----
    // Properties
    // ----
    wire logic pbad = ^{PRI_BUS.ad, PRI_BUS.cbe_n, PRI_BUS.par};
    wire logic sbad = ^{SEC_BUS.ad, SEC_BUS.cbe_n, SEC_BUS.par};
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    chk_pri_perr_delay: assert property (
        !PRIMARY_PARITY_ERROR_N |-> $past(PRI_BUS.data_phase, 2))
        else $error("primary parity error without transfer");
    chk_sec_perr_delay: assert property (
        !SECONDARY_PARITY_ERROR_N |-> $past(SEC_BUS.data_phase, 2))
        else $error("secondary parity error without transfer");
    chk_pri_claim_cause: assert property (
        !PRIMARY_DEVICE_SELECT_N |-> $past(PRI_BUS.addr_phase && PRI_BUS.hit))
        else $error("primary claim without hit");
    chk_sec_claim_cause: assert property (
        !SECONDARY_DEVICE_SELECT_N |-> $past(SEC_BUS.addr_phase && SEC_BUS.hit))
        else $error("secondary claim without hit");
    chk_good_addr_claim: assert property (
        PRI_BUS.addr_phase && PRI_BUS.hit && !pbad |=> !PRIMARY_DEVICE_SELECT_N)
        else $error("good address not claimed");
    chk_serr_addr_cause: assert property (
        !PRIMARY_SYSTEM_ERROR_N |->
        $past(PRI_BUS.addr_phase && pbad || SEC_BUS.addr_phase && sbad))
        else $error("system error without address parity error");
    chk_cfg_write_ready: assert property (
        PRI_BUS.data_phase && PRI_BUS.cfg_wr |=> !PRIMARY_TARGET_READY_N)
        else $error("config write not made ready");
    chk_retry_cause: assert property (
        !PRIMARY_STOP_N |-> $past(PRI_BUS.data_phase && PRI_BUS.dw_req))
        else $error("stop without delayed write");
    chk_fwd_after_phase: assert property (
        PRI_FWD_OUT.valid |-> $past(PRI_BUS.data_phase))
        else $error("forward without data phase");
    cover property (!PRIMARY_SYSTEM_ERROR_N);
    cover property (PRI_FWD_OUT.valid);
    cover property (!PRIMARY_STOP_N && PRIMARY_TARGET_READY_N);
endmodule
bind bpe_parity_core bpe_chk u_chk (
    .CORE_CLK(CORE_CLK), .RSTN(RSTN), .PRI_BUS(PRI_BUS), .SEC_BUS(SEC_BUS),
    .PRIMARY_DEVICE_SELECT_N(PRIMARY_DEVICE_SELECT_N),
    .SECONDARY_DEVICE_SELECT_N(SECONDARY_DEVICE_SELECT_N),
    .PRIMARY_TARGET_READY_N(PRIMARY_TARGET_READY_N),
    .PRIMARY_STOP_N(PRIMARY_STOP_N),
    .PRIMARY_SYSTEM_ERROR_N(PRIMARY_SYSTEM_ERROR_N),
    .PRIMARY_PARITY_ERROR_N(PRIMARY_PARITY_ERROR_N),
    .SECONDARY_PARITY_ERROR_N(SECONDARY_PARITY_ERROR_N),
    .PRI_FWD_OUT(PRI_FWD_OUT));
`default_nettype wire

/* testbench/bpe_initiator_model.sv */
// Initiator on the primary bus that takes read data returned to it.
// Assumes all byte enables active; the error line has a pull-up.
`default_nettype none
module bpe_initiator_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire bpe_pkg::bpe_fwd_t fwd,
    input wire logic report_en,
    output logic perr_n
);
    logic [1:0] seen;
    // Bad read data is reported two cycles after the transfer.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen <= 2'h0;
        end else begin
            seen <= {seen[0], fwd.valid && report_en && ^{fwd.ad, fwd.par}};
        end
    end
    assign perr_n = !seen[1];
endmodule
`default_nettype wire

/* testbench/test_bpe_parity_core.sv */
// Self-checking bench of the parity and error block.
// Assumes the design package and the primary initiator model.
`default_nettype none
module test_bpe_parity_core;
    timeunit 1ns;
    timeprecision 1ns;
    localparam bpe_pkg::bpe_bus_t IDLE = '{perr_n: 1'b1, default: '0};
    logic clk, rstn = 0, cfg_rd = 0, ip_n;
    logic [7:0] cfg_addr = 8'h00;
    bpe_pkg::bpe_bus_t pb = IDLE, sb = IDLE, pi, a, v;
    logic [31:0] rdata, rd;
    logic dv_p, dv_s, ry_p, ry_s, st_p, st_s, serr, pe_p, pe_s;
    logic [1:0] kept;
    bpe_pkg::bpe_fwd_t fw_p, fw_s;
    logic s, en, r, b, h, e_dv, e_se;
    int fails = 0, check_count = 0, cycles = 0;
    logic [6:0] rows [8] = '{7'b0111110, 7'b0101101, 7'b0110101,
        7'b0110011, 7'b1111110, 7'b1101101, 7'b1110101, 7'b0011111};
    always_comb begin
        pi = pb;
        pi.perr_n = pb.perr_n & ip_n;
    end
    bpe_parity_core u_dut (.CORE_CLK(clk), .RSTN(rstn), .PRI_BUS(pi),
        .SEC_BUS(sb), .CFG_RD(cfg_rd), .CFG_ADDR(cfg_addr), .CFG_RDATA(rdata),
        .PRIMARY_DEVICE_SELECT_N(dv_p), .SECONDARY_DEVICE_SELECT_N(dv_s),
        .PRIMARY_TARGET_READY_N(ry_p), .SECONDARY_TARGET_READY_N(ry_s),
        .PRIMARY_STOP_N(st_p), .SECONDARY_STOP_N(st_s),
        .PRIMARY_SYSTEM_ERROR_N(serr), .PRIMARY_PARITY_ERROR_N(pe_p),
        .SECONDARY_PARITY_ERROR_N(pe_s), .PRI_FWD_OUT(fw_p),
        .SEC_FWD_OUT(fw_s), .DW_KEPT_ERROR(kept));
    bpe_initiator_model u_ini (.clk(clk), .rst_n(rstn), .fwd(fw_p),
        .report_en(1'b1), .perr_n(ip_n));
    // ----
    // Tasks
    // ----
    task automatic chk(input string nm, input logic [63:0] e, g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic bpe_pkg::bpe_bus_t mk(input logic [31:0] ad,
                                             input logic [3:0] c,
                                             input logic bad);
        mk = IDLE;
        mk.ad = ad;
        mk.cbe_n = c;
        mk.par = ^{ad, c} ^ bad;
    endfunction
    task automatic send(input logic sec, bpe_pkg::bpe_bus_t x,
                        input logic [7:0] ofs);
        @(posedge clk);
        cfg_addr <= ofs;
        if (sec) sb <= x;
        else pb <= x;
        @(posedge clk);
        pb <= IDLE;
        sb <= IDLE;
        #1;
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic rdreg(input logic [7:0] ofs);
        @(posedge clk);
        cfg_addr <= ofs;
        cfg_rd <= 1'b1;
        @(posedge clk);
        cfg_rd <= 1'b0;
        #1;
        rd = rdata;
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [31:0] d,
                      input logic bad);
        bpe_pkg::bpe_bus_t x;
        x = mk(d, 4'h0, bad);
        x.data_phase = 1'b1;
        x.cfg_wr = 1'b1;
        send(1'b0, x, ofs);
    endtask
    task automatic setup(input logic [15:0] cmd, input logic br);
        wr(8'h04, {16'hFFFF, cmd}, 1'b0);
        wr(8'h3C, {15'h0, br, 16'h0}, 1'b0);
        wr(8'h1C, 32'hFFFF0000, 1'b0);
    endtask
    task automatic dw(input logic q, bpe_pkg::bpe_bus_t d,
                      input logic [1:0] e);
        send(q, a, 8'h00);
        send(q, d, 8'h00);
        chk("dw_ready_stop", e, q ? {ry_s, st_s} : {ry_p, st_p});
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ----
    // Stimulus
    // ----
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rdreg(8'h04);
        chk("cmd_reset", 0, rd);
        rdreg(8'h1C);
        chk("sec_reset", 0, rd);
        wr(8'h10, 32'hFFFFFFFF, 1'b0);
        rdreg(8'h10);
        chk("unmapped", 0, rd);
        foreach (rows[i]) begin
            {s, en, r, b, h, e_dv, e_se} = rows[i];
            setup({7'h0, en, 1'b0, r, 6'h0}, r);
            v = mk(32'h00001000, 4'h7, b);
            v.addr_phase = 1'b1;
            v.hit = h;
            send(s, v, 8'h00);
            chk("devsel", e_dv, s ? dv_s : dv_p);
            chk("serr", e_se, serr);
            rdreg(8'h04);
            chk("sig_serr", !e_se, rd[30]);
            rdreg(s ? 8'h1C : 8'h04);
            chk("det_addr", b, rd[31]);
        end
        for (int i = 0; i < 2; i++) begin
            r = i[0];
            setup({9'h0, r, 6'h0}, 1'b0);
            wr(8'h04, {16'h0, 9'h0, r, 6'h05}, 1'b1);
            chk("cfg_ready", 0, ry_p);
            step();
            chk("cfg_perr", !r, pe_p);
            rdreg(8'h04);
            chk("cfg_data", {16'h8000, 9'h0, r, 6'h05}, rd);
        end
        setup(16'h0140, 1'b1);
        v = mk(32'hA5A50F0F, 4'h0, 1'b1);
        v.data_phase = 1'b1;
        v.rd_target = 1'b1;
        send(1'b1, v, 8'h00);
        step();
        chk("rd_perr_s", 0, pe_s);
        rdreg(8'h1C);
        chk("rd_sstat", 32'h81000000, rd);
        v.rd_target = 1'b0;
        v.rd_return = 1'b1;
        send(1'b0, v, 8'h00);
        chk("fwd_p", {1'b1, v.ad, v.par}, fw_p);
        repeat (4) step();
        rdreg(8'h04);
        chk("pstat_quiet", 32'h00000140, rd);
        v.rd_return = 1'b0;
        v.rd_target = 1'b1;
        send(1'b0, v, 8'h00);
        step();
        chk("rd_perr_p", 0, pe_p);
        v = IDLE;
        v.rd_discard = 1'b1;
        send(1'b1, v, 8'h00);
        v = IDLE;
        v.data_phase = 1'b1;
        v.rd_return = 1'b1;
        send(1'b1, v, 8'h00);
        chk("discard", 0, fw_s.valid);
        setup(16'h0040, 1'b0);
        a = mk(32'h00002000, 4'h7, 1'b0);
        a.addr_phase = 1'b1;
        a.hit = 1'b1;
        for (int i = 0; i < 3; i++) begin
            v = mk(32'h12345678 + (i == 1), 4'h0, 1'b0);
            v.data_phase = 1'b1;
            v.dw_req = 1'b1;
            dw(1'b0, v, i == 2 ? 2'b01 : 2'b10);
        end
        v.ad = 32'hCAFE0001;
        v.par = ~^v.ad;
        v.more = 1'b1;
        dw(1'b0, v, 2'b00);
        step();
        chk("dw_perr", 0, pe_p);
        rdreg(8'h04);
        chk("dw_det", 1, rd[31]);
        wr(8'h04, 32'hFFFF0000, 1'b0);
        v.more = 1'b0;
        dw(1'b0, v, 2'b10);
        step();
        chk("dw_no_perr", 1, pe_p);
        rdreg(8'h04);
        chk("dw_det_clr", 1, rd[31]);
        dw(1'b1, v, 2'b10);
        wr(8'h3C, 32'h00010000, 1'b0);
        a = IDLE;
        a.dw_deliver = 1'b1;
        a.data_phase = 1'b1;
        a.perr_n = 1'b0;
        send(1'b1, a, 8'h00);
        chk("dw_fwd", {1'b1, v.ad, v.par}, fw_s);
        chk("dw_kept", 2'b01, kept);
        rdreg(8'h1C);
        chk("dw_sdpar", 1, rd[24]);
        send(1'b0, a, 8'h00);
        chk("dw_kept_p", 2'b11, kept);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rdreg(8'h04);
        chk("cmd_rereset", 0, rd);
        chk("kept_rereset", 0, kept);
        tally_and_finish();
    end
endmodule
`default_nettype wire
